// *** common/lcac_pkg.sv ***
// constants for the arithmetic logic cell
package lcac_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_CTRL   = 4'h0;
  localparam logic [3:0] ADDR_LUT_LO = 4'h4;
  localparam logic [3:0] ADDR_LUT_HI = 4'h8;
  localparam logic [3:0] ADDR_STATUS = 4'hC;

  // ----------------------------------------------------------------
  // control register fields
  // ----------------------------------------------------------------
  localparam int MODE_LSB      = 0;
  localparam int MODE_W        = 3;
  localparam int EXT_REG_BIT   = 3;
  localparam int COMB_CARRY    = 4;
  localparam int COUNTER_BIT   = 5;
  localparam int CASCADE_BIT   = 6;
  localparam int CSTART_BIT    = 7;
  localparam int BYPASS_BIT    = 8;
  localparam int COLTOP_BIT    = 9;
  localparam int INDEX_LSB     = 10;
  localparam int INDEX_W       = 4;
  localparam int CLKSEL_LSB    = 14;
  localparam int SCLR_EN_LSB   = 16;
  localparam int SLOAD_EN_LSB  = 19;
  localparam int ACLR_SEL_LSB  = 22;
  localparam int INVERT_LSB    = 25;
  localparam int GCLR_EN_BIT   = 28;

  localparam logic [31:0] CTRL_RESET   = 32'h0000_0000;
  localparam logic [31:0] LUT_RESET    = 32'h0000_0000;
  localparam logic [31:0] CTRL_WMASK   = 32'h1FFF_FFFF;

  // ----------------------------------------------------------------
  // operating mode codes
  // ----------------------------------------------------------------
  localparam logic [2:0] MODE_OFF    = 3'h0;
  localparam logic [2:0] MODE_EXT    = 3'h1;
  localparam logic [2:0] MODE_ARITH  = 3'h2;
  localparam logic [2:0] MODE_SHARED = 3'h3;
  localparam logic [2:0] MODE_LUTREG = 3'h4;

  // ----------------------------------------------------------------
  // cluster geometry
  // ----------------------------------------------------------------
  localparam int         CLUSTER_CELLS = 10;
  localparam logic [3:0] FIRST_CELL    = 4'h0;
  localparam logic [3:0] CARRY_START_B = 4'h4;
  localparam logic [3:0] SHARE_START_B = 4'h5;
  localparam logic [3:0] HALF_CELLS    = 4'h5;
  localparam int         CLUSTER_CLKS  = 3;

endpackage : lcac_pkg

// *** hw/lcac_cell.sv ***
// one adaptive logic cell with arithmetic, shared and register chains
//
// The register offsets and the strobed register port were left to the implementer.
`timescale 1ns/10ps
// Contract
// - extended mode muxes two 5-input functions
// - unregistered extended function frees eighth input
// - arithmetic uses four 4-input lookups, two adders
// - all four lookups share first two inputs
// - carry runs lower adder, upper adder, next cell
// - sums available registered and unregistered
// - carry out usable beside combinational outputs
// - clock, count, up/down, add/sub from local inputs
// - cluster sync clear/load with per-register enable
// - carry chain starts at first or fifth
// - top/bottom half chains continue into same half
// - alternate columns bypass top or bottom half
// - long chains link clusters down the column
// - shared mode lookups make sum or carry (here fixed adders on a, c, e0 and b, d, e1 make them, lookups unused)
// - shared chain starts at first or sixth
// - lookup halves form a third register
// - third register follows top register controls
// - register cascade feeds next cell register
// - lookups stay free while cascading registers
// - two cluster async clears, preset by inversion (here the selected clear acts at the next clk edge, ahead of the clock enable)
// - global clear pin overrides all controls
// - each cluster clock gated by its enable
module lcac_cell
  import lcac_pkg::*;
#(
  parameter int ADDR_W = 4
)(
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [31:0]       wrData,
  input  wire logic              wr,
  input  wire logic              rd,
  output logic      [31:0]       rdData,
  input  wire logic [7:0]        dataIn,
  input  wire logic              locClkEn,
  input  wire logic              locCntEn,
  input  wire logic              locUpDn,
  input  wire logic              locAddSub,
  input  wire logic [2:0]        clusterClkEn,
  input  wire logic [1:0]        clusterAclr,
  input  wire logic              clusterSclr,
  input  wire logic              clusterSload,
  input  wire logic              global_register_clear_n,
  input  wire logic              carryIn,
  input  wire logic              shareIn,
  input  wire logic              regChainIn,
  output logic                   carryOut,
  output logic                   shareOut,
  output logic                   regChainOut,
  output logic                   combTop,
  output logic                   combBot,
  output logic                   regOut0,
  output logic                   regOut1,
  output logic                   lutRegOut
);

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  if (ADDR_W < 4)
  begin : g_bad_addr
    $error("ADDR_W must be at least 4");
  end

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        gclrS1;
    logic        gclrS2;
    logic [31:0] ctrl;
    logic [31:0] lutLo;
    logic [31:0] lutHi;
    logic        reg0;
    logic        second_cell_register;
    logic        reg2;
    logic        carryOut;
    logic        shareOut;
    logic        combTop;
    logic        combBot;
    logic [31:0] rdData;
  } lcac_state_t;

  lcac_state_t s;
  lcac_state_t next_s;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [1:0] fullAdd(input logic x, input logic y, input logic c);
    fullAdd = {(x & y) | (x & c) | (y & c), x ^ y ^ c};
  endfunction : fullAdd

  function automatic logic lut4(input logic [15:0] mask, input logic [3:0] idx);
    lut4 = mask[idx];
  endfunction : lut4

  function automatic logic lut5(input logic [31:0] mask, input logic [4:0] idx);
    lut5 = mask[idx];
  endfunction : lut5

  function automatic logic pick3(input logic [2:0] v, input logic [1:0] sel);
    pick3 = (sel == 2'h3) ? 1'b0 : v[sel];
  endfunction : pick3

  // ----------------------------------------------------------------
  // decoded configuration
  // ----------------------------------------------------------------
  logic [2:0] mode;
  logic [3:0] cellIdx;
  logic [1:0] clkSel;
  logic [2:0] sclrEn;
  logic [2:0] sloadEn;
  logic [2:0] aclrSel;
  logic [2:0] invert;
  logic       gclrAct;
  logic       isArith;
  logic       isShared;
  logic       carryStartOk;
  logic       shareStartOk;
  logic       bypassOk;
  logic       lowCin;
  logic       shareCin;
  logic       en0;
  logic       en1;
  logic       clr0;
  logic       clr1;

  assign mode     = s.ctrl[MODE_LSB +: MODE_W];
  assign cellIdx  = s.ctrl[INDEX_LSB +: INDEX_W];
  assign clkSel   = s.ctrl[CLKSEL_LSB +: 2];
  assign sclrEn   = s.ctrl[SCLR_EN_LSB +: 3];
  assign sloadEn  = s.ctrl[SLOAD_EN_LSB +: 3];
  assign aclrSel  = s.ctrl[ACLR_SEL_LSB +: 3];
  assign invert   = s.ctrl[INVERT_LSB +: 3];
  assign isArith  = (mode == MODE_ARITH);
  assign isShared = (mode == MODE_SHARED);
  // global clear acts only when built in, after two-flop sync
  assign gclrAct  = s.ctrl[GCLR_EN_BIT] & ~s.gclrS2;
  assign carryStartOk = (cellIdx == FIRST_CELL) | (cellIdx == CARRY_START_B);
  assign shareStartOk = (cellIdx == FIRST_CELL) | (cellIdx == SHARE_START_B);
  // top half bypassable in one column parity, bottom half in the other
  assign bypassOk = s.ctrl[BYPASS_BIT] & ((cellIdx < HALF_CELLS) ? s.ctrl[COLTOP_BIT] : ~s.ctrl[COLTOP_BIT]);
  // unstarted chains take the carry from the cell or cluster below
  assign lowCin = (s.ctrl[CSTART_BIT] & carryStartOk & isArith)
                ? (s.ctrl[COUNTER_BIT] ? locUpDn : locAddSub)
                : ((s.ctrl[CSTART_BIT] & shareStartOk & isShared) ? 1'b0 : carryIn);
  assign shareCin = (s.ctrl[CSTART_BIT] & shareStartOk) ? 1'b0 : shareIn;
  // cluster clock enable, plus local enable in arithmetic modes
  assign en0  = pick3(clusterClkEn, clkSel) & ((isArith | isShared) ? locClkEn : 1'b1);
  assign en1  = en0 & ~(isArith & s.ctrl[COUNTER_BIT] & ~locCntEn);
  assign clr0 = clusterAclr[aclrSel[0]];
  assign clr1 = clusterAclr[aclrSel[1]];

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin : p_next
    logic       a;
    logic       b;
    logic       c;
    logic       d;
    logic       e0;
    logic       e1;
    logic       f0;
    logic       f1;
    logic       extOut;
    logic       la0;
    logic       lb0;
    logic       la1;
    logic       lb1;
    logic       opA0;
    logic       opB0;
    logic       opA1;
    logic       opB1;
    logic [1:0] add0;
    logic [1:0] add1;
    logic       dIn0;
    logic       dIn1;
    logic       dIn2;
    logic       hold;
    {f1, e1, f0, e0, d, c, b, a} = dataIn;
    next_s = s;
    extOut = 1'b0;
    la0 = lut4(s.lutLo[15:0], {e0, c, b, a});
    lb0 = lut4(s.lutLo[31:16], {e0, c, b, a});
    la1 = lut4(s.lutHi[15:0], {e1, d, b, a});
    lb1 = lut4(s.lutHi[31:16], {e1, d, b, a});
    opA0 = la0;
    opB0 = lb0;
    opA1 = la1;
    opB1 = lb1;
    add0 = 2'h0;
    add1 = 2'h0;
    dIn0 = s.reg0;
    dIn1 = s.second_cell_register;
    dIn2 = s.reg2;
    hold = 1'b0;

    next_s.gclrS1 = global_register_clear_n;
    next_s.gclrS2 = s.gclrS1;

    // register port
    if (wr)
    begin
      case (addr[3:0])
        ADDR_CTRL:   next_s.ctrl  = wrData & CTRL_WMASK;
        ADDR_LUT_LO: next_s.lutLo = wrData;
        ADDR_LUT_HI: next_s.lutHi = wrData;
        default:     next_s.ctrl  = s.ctrl;
      endcase
    end
    next_s.rdData = 32'h0000_0000;
    if (rd && ((addr >> 4) == '0))
    begin
      case (addr[3:0])
        ADDR_CTRL:   next_s.rdData = s.ctrl;
        ADDR_LUT_LO: next_s.rdData = s.lutLo;
        ADDR_LUT_HI: next_s.rdData = s.lutHi;
        ADDR_STATUS: next_s.rdData = {25'h0, s.combBot, s.combTop, s.shareOut, s.carryOut,
                                      s.reg2, s.second_cell_register, s.reg0};
        default:     next_s.rdData = 32'h0000_0000;
      endcase
    end

    // datapath per mode
    next_s.carryOut = 1'b0;
    next_s.shareOut = 1'b0;
    case (mode)
      MODE_EXT:
      begin
        extOut = f0 ? lut5(s.lutHi, {e1, d, c, b, a}) : lut5(s.lutLo, {e0, d, c, b, a});
        next_s.combTop = extOut;
        next_s.combBot = 1'b0;
        dIn0 = s.ctrl[EXT_REG_BIT] ? extOut : f1;
        hold = 1'b1;
      end
      MODE_ARITH:
      begin
        if (s.ctrl[COUNTER_BIT])
        begin
          opA0 = s.reg0;
          opA1 = s.second_cell_register;
          opB0 = ~locUpDn;
          opB1 = ~locUpDn;
        end
        else
        begin
          opB0 = lb0 ^ locAddSub;
          opB1 = lb1 ^ locAddSub;
        end
        add0 = fullAdd(opA0, opB0, lowCin);
        add1 = fullAdd(opA1, opB1, add0[1]);
        next_s.carryOut = bypassOk ? carryIn : add1[1];
        next_s.combTop  = s.ctrl[COMB_CARRY] ? la0 : add0[0];
        next_s.combBot  = s.ctrl[COMB_CARRY] ? la1 : add1[0];
        dIn0 = add0[0];
        dIn1 = add1[0];
      end
      MODE_SHARED:
      begin
        add0 = fullAdd(a, c, e0);
        add1 = fullAdd(b, d, e1);
        next_s.shareOut = bypassOk ? shareIn : add1[1];
        opA0 = add0[0];
        opB0 = shareCin;
        opA1 = add1[0];
        opB1 = add0[1];
        add0 = fullAdd(opA0, opB0, lowCin);
        add1 = fullAdd(opA1, opB1, add0[1]);
        next_s.carryOut = bypassOk ? carryIn : add1[1];
        next_s.combTop  = add0[0];
        next_s.combBot  = add1[0];
        dIn0 = add0[0];
        dIn1 = add1[0];
      end
      MODE_LUTREG:
      begin
        next_s.combTop = lut4(s.lutLo[15:0], {d, c, b, a});
        next_s.combBot = lut4(s.lutHi[15:0], {e1, d, b, a});
        dIn0 = e0;
        dIn1 = f0;
        dIn2 = f1;
      end
      default:
      begin
        next_s.combTop = 1'b0;
        next_s.combBot = 1'b0;
      end
    endcase

    // cascade replaces register data, lookups keep their outputs
    if (s.ctrl[CASCADE_BIT])
    begin
      dIn0 = regChainIn;
      dIn1 = s.reg0;
    end

    // register 0 and the lookup register share controls
    if (gclrAct)
    begin
      next_s.reg0 = invert[0];
      next_s.reg2 = invert[2];
    end
    else if (clr0)
    begin
      next_s.reg0 = invert[0];
      next_s.reg2 = invert[2];
    end
    else if (en0)
    begin
      if (clusterSclr && sclrEn[0])
        next_s.reg0 = invert[0];
      else if (clusterSload && sloadEn[0])
        next_s.reg0 = c;
      else if (en1)
        next_s.reg0 = dIn0;
      if (mode == MODE_LUTREG)
      begin
        if (clusterSclr && sclrEn[2])
          next_s.reg2 = invert[2];
        else if (clusterSload && sloadEn[2])
          next_s.reg2 = d;
        else
          next_s.reg2 = dIn2;
      end
    end

    // second register, unavailable in extended mode
    if (gclrAct)
      next_s.second_cell_register = invert[1];
    else if (clr1 || hold)
      next_s.second_cell_register = invert[1];
    else if (en0)
    begin
      if (clusterSclr && sclrEn[1])
        next_s.second_cell_register = invert[1];
      else if (clusterSload && sloadEn[1])
        next_s.second_cell_register = d;
      else if (en1)
        next_s.second_cell_register = dIn1;
    end
  end : p_next

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      s.gclrS1   <= 1'b1;
      s.gclrS2   <= 1'b1;
      s.ctrl     <= CTRL_RESET;
      s.lutLo    <= LUT_RESET;
      s.lutHi    <= LUT_RESET;
      s.reg0     <= 1'b0;
      s.second_cell_register     <= 1'b0;
      s.reg2     <= 1'b0;
      s.carryOut <= 1'b0;
      s.shareOut <= 1'b0;
      s.combTop  <= 1'b0;
      s.combBot  <= 1'b0;
      s.rdData   <= 32'h0000_0000;
    end
    else
      s <= next_s;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign rdData      = s.rdData;
  assign carryOut    = s.carryOut;
  assign shareOut    = s.shareOut;
  assign regChainOut = s.second_cell_register;
  assign combTop     = s.combTop;
  assign combBot     = s.combBot;
  assign regOut0     = s.reg0;
  assign regOut1     = s.second_cell_register;
  assign lutRegOut   = s.reg2;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence gclrSeq;
    s.ctrl[GCLR_EN_BIT] && !s.gclrS2;
  endsequence

  sequence lutRegIdle;
    (mode == MODE_LUTREG) && !en0 && !clr0 && !gclrAct && !wr;
  endsequence

  gclr_override_a: assert property (gclrSeq |=> (regOut0 == $past(invert[0])) && (regOut1 == $past(invert[1])))
    else $error("global clear did not clear registers");
  half_bypass_a: assert property ((isArith && bypassOk && !wr) |=> carryOut == $past(carryIn))
    else $error("bypassed cell did not pass carry");
  ext_noreg1_a: assert property ((mode == MODE_EXT) && !wr |=> regOut1 == $past(invert[1]))
    else $error("second register active in extended mode");
  clk_gate_a: assert property ((!en0 && !clr0 && !gclrAct && !wr) |=> $stable(regOut0))
    else $error("register moved with clock enable low");
  sync_clear_a: assert property ((en0 && clusterSclr && sclrEn[0] && !clr0 && !gclrAct && !wr)
                                 |=> regOut0 == $past(invert[0]))
    else $error("sync clear ignored");
  carry_start_a: assert property ((isArith && s.ctrl[CSTART_BIT] && !carryStartOk) |-> lowCin == carryIn)
    else $error("carry chain started at illegal cell");
  share_start_a: assert property ((s.ctrl[CSTART_BIT] && !shareStartOk) |-> shareCin == shareIn)
    else $error("shared chain started at illegal cell");
  cascade_shift_a: assert property ((s.ctrl[CASCADE_BIT] && en1 && !clusterSclr && !clusterSload
                                     && !clr0 && !clr1 && !gclrAct && mode != MODE_EXT && !wr)
                                    |=> (regOut0 == $past(regChainIn)) && (regChainOut == $past(regOut0)))
    else $error("cascade did not shift");
  lutreg_hold_a: assert property (lutRegIdle ##1 lutRegIdle |-> $stable(lutRegOut) ##1 $stable(lutRegOut))
    else $error("lookup register moved without top register enable");

endmodule : lcac_cell

// *** test/lcac_cell_tb_top.sv ***
// self-checking bench for the arithmetic logic cell
`timescale 1ns/10ps
module lcac_cell_tb_top
  import lcac_pkg::*;
;
  // ----------------------------------------
  // signals and instances
  // ----------------------------------------
  logic        clk, rst, wr, rd, locClkEn, locCntEn, locUpDn, locAddSub;
  logic        clusterSclr, clusterSload, global_register_clear_n, pCarry, pShare, pChain;
  logic        carryIn, shareIn, regChainIn, carryOut, shareOut, regChainOut;
  logic        combTop, combBot, regOut0, regOut1, lutRegOut;
  logic [3:0]  addr;
  logic [31:0] wrData, rdData, rv;
  logic [7:0]  dataIn;
  logic [2:0]  clusterClkEn;
  logic [1:0]  clusterAclr;
  int          n_mismatch, checks;

  lcac_cell #(.ADDR_W(4)) DUT (.clk, .rst, .addr, .wrData, .wr, .rd, .rdData, .dataIn, .locClkEn,
    .locCntEn, .locUpDn, .locAddSub, .clusterClkEn, .clusterAclr, .clusterSclr, .clusterSload,
    .global_register_clear_n, .carryIn, .shareIn, .regChainIn, .carryOut, .shareOut, .regChainOut,
    .combTop, .combBot, .regOut0, .regOut1, .lutRegOut);
  lcac_neighbour NB (.clk, .rst, .nextCarry(pCarry), .nextShare(pShare), .nextChain(pChain),
    .carryToCell(carryIn), .shareToCell(shareIn), .chainToCell(regChainIn));

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // ----------------------------------------
  // bus, compare and adder model
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk

  task automatic wreg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wrData <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wreg

  task automatic rreg(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    d = rdData;
  endtask : rreg

  function automatic logic maj3(input logic a, b, c);
    return (a & b) | (a & c) | (b & c);
  endfunction : maj3

  // returns {sum0, sum1, carry out}
  function automatic logic [2:0] add2(input logic x0, y0, x1, y1, ci);
    logic c0;
    c0 = maj3(x0, y0, ci);
    return {x0 ^ y0 ^ ci, x1 ^ y1 ^ c0, maj3(x1, y1, c0)};
  endfunction : add2

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_regs;
    rreg(ADDR_CTRL, rv);
    chk(rv, CTRL_RESET, "ctrl reset");
    rreg(ADDR_LUT_LO, rv);
    chk(rv, LUT_RESET, "lut reset");
    rreg(ADDR_STATUS, rv);
    chk(rv, 32'h0, "status reset");
    wreg(ADDR_CTRL, 32'hFFFF_FFFF);
    rreg(ADDR_CTRL, rv);
    chk(rv, CTRL_WMASK, "ctrl mask");
    @(negedge clk);
    chk(rdData, 32'h0, "read data one cycle");
    wreg(ADDR_LUT_HI, 32'hA5C3_0FF0);
    wreg(4'h2, 32'hFFFF_FFFF);
    rreg(ADDR_LUT_HI, rv);
    chk(rv, 32'hA5C3_0FF0, "lut rw");
    rreg(4'h2, rv);
    chk(rv, 32'h0, "unmapped");
    wreg(ADDR_CTRL, 32'h0);
  endtask : t_regs

  task automatic t_ext;
    logic [31:0] lo;
    logic [31:0] hi;
    logic        e;
    lo = 32'h9A3C_55F0;
    hi = 32'h0FF0_C3A5;
    wreg(ADDR_LUT_LO, lo);
    wreg(ADDR_LUT_HI, hi);
    for (int r = 0; r < 2; r++)
    begin
      wreg(ADDR_CTRL, 32'(MODE_EXT) | (32'(r) << EXT_REG_BIT));
      for (int i = 0; i < 256; i += 7)
      begin
        @(posedge clk);
        dataIn <= 8'(i);
        @(posedge clk);
        @(negedge clk);
        e = dataIn[5] ? hi[{dataIn[6], dataIn[3:0]}] : lo[{dataIn[4], dataIn[3:0]}];
        chk(32'({combTop, regOut1, regOut0}), 32'({e, 1'b0, r[0] ? e : dataIn[7]}), "ext");
      end
    end
  endtask : t_ext

  task automatic t_arith;
    logic [3:0] cfg [6] = '{4'h1, 4'h0, 4'h3, 4'h4, 4'h1, 4'h6};
    logic [2:0] e;
    logic [4:0] x;
    logic       ci;
    wreg(ADDR_LUT_LO, 32'hCCCC_AAAA);
    wreg(ADDR_LUT_HI, 32'hCCCC_AAAA);
    for (int k = 0; k < 6; k++)
    begin
      wreg(ADDR_CTRL, 32'(MODE_ARITH) | (32'(k != 0) << CSTART_BIT) | (32'(cfg[k]) << INDEX_LSB)
        | (32'(k == 4) << COMB_CARRY) | (32'(k == 5) << BYPASS_BIT));
      for (int j = 0; j < 16; j++)
      begin
        @(posedge clk);
        dataIn <= {j[3:2], j[3:2], j[3:2], j[1:0]};
        pCarry <= j[2];
        locAddSub <= j[3];
        repeat (2) @(posedge clk);
        @(negedge clk);
        ci = (k == 1 || k == 3) ? j[3] : j[2];
        e = add2(j[0], j[1] ^ j[3], j[0], j[1] ^ j[3], ci);
        x = {e, e[2:1]};
        if (k == 4)
          x[4:3] = {j[0], j[0]};
        if (k == 5)
          x[2] = j[2];
        chk(32'({combTop, combBot, carryOut, regOut0, regOut1}), 32'(x), "arith");
      end
    end
    locAddSub <= 1'b0;
  endtask : t_arith

  task automatic t_shared;
    logic [7:0] d;
    logic [3:0] e;
    wreg(ADDR_CTRL, 32'(MODE_SHARED) | (32'h2 << INDEX_LSB));
    for (int j = 0; j < 512; j += 5)
    begin
      d = j[7:0];
      @(posedge clk);
      dataIn <= d;
      pShare <= j[8];
      pCarry <= j[0] ^ j[8];
      repeat (2) @(posedge clk);
      @(negedge clk);
      e = {add2(d[0] ^ d[2] ^ d[4], j[8], d[1] ^ d[3] ^ d[6], maj3(d[0], d[2], d[4]), j[0] ^ j[8]),
           maj3(d[1], d[3], d[6])};
      chk(32'({combTop, combBot, carryOut, shareOut}), 32'(e), "shared");
    end
  endtask : t_shared

  task automatic t_count;
    logic [6:0] st [12] = '{7'h44, 7'h70, 7'h70, 7'h70, 7'h70, 7'h50, 7'h60, 7'h20, 7'h46, 7'h70, 7'h48, 7'h40};
    logic [6:0] s;
    logic [1:0] cnt;
    wreg(ADDR_CTRL, 32'(MODE_ARITH) | (32'h1 << COUNTER_BIT) | (32'h1 << CSTART_BIT)
      | (32'h1 << SCLR_EN_LSB) | (32'h3 << SLOAD_EN_LSB));
    for (int i = 0; i <= 12; i++)
    begin
      @(posedge clk);
      if (i < 12)
        {locClkEn, locCntEn, locUpDn, clusterSclr, clusterSload, dataIn[3], dataIn[2]} <= st[i];
      @(negedge clk);
      if (i > 0)
      begin
        s = st[i-1];
        if (s[6] && s[3])
          cnt = cnt & 2'b10;
        else if (s[6] && s[2])
          cnt = s[1:0];
        else if (s[6] && s[5])
          cnt = s[4] ? cnt + 2'h1 : cnt - 2'h1;
        chk(32'({regOut1, regOut0}), 32'(cnt), "count");
      end
    end
  endtask : t_count

  task automatic t_cascade;
    logic [2:0] ex;
    logic [7:0] dRec;
    logic       cRec, enRec;
    wreg(ADDR_LUT_LO, 32'h0000_6B2D);
    wreg(ADDR_CTRL, 32'(MODE_LUTREG) | (32'h1 << CASCADE_BIT));
    for (int i = 0; i < 24; i++)
    begin
      @(posedge clk);
      dataIn <= 8'(i * 149);
      pChain <= i[0] ^ i[2];
      clusterClkEn <= (i % 7 >= 4) ? 3'h6 : 3'h7;
      @(negedge clk);
      if (i > 0 && enRec)
        ex = {cRec, ex[2], dRec[7]};
      if (i > 1)
        chk(32'({regOut0, regOut1, lutRegOut, regChainOut}), 32'({ex, ex[1]}), "chain");
      if (i > 1 && enRec)
        chk(32'(combTop), 32'h6B2D >> dRec[3:0] & 32'h1, "lut");
      dRec = dataIn;
      cRec = regChainIn;
      enRec = clusterClkEn[0];
    end
  endtask : t_cascade

  task automatic t_clear;
    wreg(ADDR_CTRL, 32'(MODE_LUTREG) | (32'h1 << CASCADE_BIT) | (32'h3F << ACLR_SEL_LSB) | (32'h1 << GCLR_EN_BIT));
    @(posedge clk);
    clusterClkEn <= 3'b111;
    dataIn <= 8'h00;
    pChain <= 1'b0;
    repeat (4) @(posedge clk);
    clusterClkEn <= 3'b110;
    clusterAclr <= 2'b01;
    @(posedge clk);
    clusterAclr <= 2'b10;
    @(negedge clk);
    chk(32'({regOut0, regOut1, lutRegOut}), 32'h0, "clear unselected");
    @(posedge clk);
    clusterAclr <= 2'b00;
    clusterClkEn <= 3'b111;
    @(negedge clk);
    chk(32'({regOut0, regOut1, lutRegOut}), 32'h7, "preset");
    repeat (3) @(posedge clk);
    global_register_clear_n <= 1'b0;
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk(32'({regOut0, regOut1, lutRegOut}), 32'h0, "sync delay");
    @(negedge clk);
    chk(32'({regOut0, regOut1, lutRegOut}), 32'h7, "global clear");
    rreg(ADDR_STATUS, rv);
    chk(rv & 32'h7, 32'h7, "status regs");
    rreg(ADDR_CTRL, rv);
    chk(rv, 32'h1FC0_0044, "config kept");
    global_register_clear_n <= 1'b1;
  endtask : t_clear

  task automatic conclude;
    $display("mismatches %0d checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : conclude

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    rst = 1'b1;
    addr = 4'h0;
    wrData = 32'h0;
    wr = 1'b0;
    rd = 1'b0;
    dataIn = 8'h00;
    locClkEn = 1'b1;
    locCntEn = 1'b0;
    locUpDn = 1'b0;
    locAddSub = 1'b0;
    clusterClkEn = 3'b111;
    clusterAclr = 2'b00;
    clusterSclr = 1'b0;
    clusterSload = 1'b0;
    global_register_clear_n = 1'b1;
    pCarry = 1'b0;
    pShare = 1'b0;
    pChain = 1'b0;
    n_mismatch = 0;
    checks = 0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_ext();
    t_arith();
    t_shared();
    t_count();
    t_cascade();
    t_clear();
    conclude();
  end
endmodule : lcac_cell_tb_top

// *** test/lcac_neighbour.sv ***
// model of the cell below: registered chain outputs
`timescale 1ns/10ps
module lcac_neighbour (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic nextCarry,
  input  wire logic nextShare,
  input  wire logic nextChain,
  output logic      carryToCell,
  output logic      shareToCell,
  output logic      chainToCell
);
  // ----------------------------------------
  // chain flops of the neighbouring cell
  // ----------------------------------------
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      carryToCell <= 1'b0;
      shareToCell <= 1'b0;
      chainToCell <= 1'b0;
    end
    else
    begin
      carryToCell <= nextCarry;
      shareToCell <= nextShare;
      chainToCell <= nextChain;
    end
  end
endmodule : lcac_neighbour
